//--- logic/timer16_oc_pkg.sv
package timer16_oc_pkg;

    // =========================================================
    // sizes
    localparam int COUNT_WIDTH = 16;
    localparam int BYTE_WIDTH  = 8;
    localparam int CHANNELS    = 2;
    localparam int ADDR_WIDTH  = 3;
    localparam int MODE_WIDTH  = 4;

    // =========================================================
    // byte addresses on the 8-bit register bus
    localparam logic [2:0] ADDR_CMP_LOW [CHANNELS]  = '{3'h0, 3'h2};
    localparam logic [2:0] ADDR_CMP_HIGH [CHANNELS] = '{3'h1, 3'h3};
    localparam logic [2:0] ADDR_CONTROL             = 3'h4;
    localparam logic [2:0] ADDR_FLAGS               = 3'h5;

    // =========================================================
    // field positions: control register, then flag register
    localparam int CTRL_ACTION_LSB = 0;
    localparam int CTRL_FORCE_LSB  = 4;
    localparam int CTRL_IRQ_EN_LSB = 6;
    localparam int FLAG_LSB        = 0;

    // =========================================================
    // reset values
    localparam logic [7:0]  CONTROL_RESET    = 8'h00;
    localparam logic [15:0] COMPARE_RESET    = 16'h0000;
    localparam logic        OUTPUT_BIT_RESET = 1'b0;

    // =========================================================
    // waveform modes with a special meaning here
    localparam logic [3:0] MODE_CTC_COMPARE = 4'h4;
    localparam logic [3:0] MODE_CTC_CAPTURE = 4'hc;

    // =========================================================
    // compare output actions
    localparam logic [1:0] ACTION_NONE   = 2'h0;
    localparam logic [1:0] ACTION_TOGGLE = 2'h1;
    localparam logic [1:0] ACTION_CLEAR  = 2'h2;
    localparam logic [1:0] ACTION_SET    = 2'h3;

    typedef enum {
        CLASS_NON_PWM,
        CLASS_FAST,
        CLASS_PHASE,
        CLASS_PHASE_FREQ
    } mode_class_t;

    function automatic mode_class_t mode_class(input logic [3:0] mode);
        mode_class_t result;
        result = CLASS_NON_PWM;
        case (mode)
            4'h1, 4'h2, 4'h3, 4'ha, 4'hb: result = CLASS_PHASE;
            4'h5, 4'h6, 4'h7, 4'he, 4'hf: result = CLASS_FAST;
            4'h8, 4'h9:                   result = CLASS_PHASE_FREQ;
            default:                      result = CLASS_NON_PWM;
        endcase
        return result;
    endfunction

endpackage

//--- logic/compare_channel.sv
`timescale 1ns/1ps

module compare_channel
    import timer16_oc_pkg::*;
#(
    parameter int WIDTH = COUNT_WIDTH
)
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // counter side
    input  wire logic [WIDTH-1:0] counter_value,
    input  wire logic             timer_tick,
    input  wire logic             match_blocked,
    input  wire logic             buffered,
    input  wire logic             load_point,
    // cpu side
    input  wire logic             write_strobe,
    input  wire logic [WIDTH-1:0] write_value,
    input  wire logic             flag_clear,
    input  wire logic             irq_ack,
    // results
    output logic      [WIDTH-1:0] compare_value,
    output logic      [WIDTH-1:0] active_value,
    output logic                  match,
    output logic                  match_event,
    output logic                  compare_match_flag
);

    initial
    begin
        if (WIDTH < 2)
            $error("compare_channel: WIDTH must be at least 2");
    end

    // =========================================================
    // compare registers
    logic [WIDTH-1:0] buffer_value;

    assign compare_value = buffered ? buffer_value : active_value;

    // buffer or direct load
    // direct writes refresh the buffer too, so a later switch into a
    // buffered mode does not load a stale value
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            buffer_value <= COMPARE_RESET;
            active_value <= COMPARE_RESET;
        end
        else
        begin
            if (write_strobe)
                buffer_value <= write_value;
            if (write_strobe && !buffered)
                active_value <= write_value;
            else if (buffered && timer_tick && load_point)
                active_value <= buffer_value;
        end
    end

    // =========================================================
    // comparator and flag
    // continuous equality
    assign match = (counter_value == active_value);

    assign match_event = timer_tick && match && !match_blocked;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            compare_match_flag <= 1'b0;
        else
            compare_match_flag <= match_event || (compare_match_flag && !flag_clear && !irq_ack);
    end

endmodule

//--- logic/timer16_output_compare.sv
`timescale 1ns/1ps

module timer16_output_compare
    import timer16_oc_pkg::*;
#(
    parameter int WIDTH = COUNT_WIDTH
)
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // register bus
    input  wire logic [ADDR_WIDTH-1:0] bus_addr,
    input  wire logic                  bus_wr,
    input  wire logic                  bus_rd,
    input  wire logic [BYTE_WIDTH-1:0] bus_wdata,
    output logic      [BYTE_WIDTH-1:0] bus_rdata,
    // counter unit
    input  wire logic [WIDTH-1:0]      counter_value,
    input  wire logic                  timer_tick,
    input  wire logic                  counter_at_top,
    input  wire logic                  counter_at_bottom,
    input  wire logic                  counter_counting_down,
    input  wire logic                  counter_write,
    input  wire logic [WIDTH-1:0]      capture_register,
    input  wire logic [MODE_WIDTH-1:0] waveform_mode_select,
    output logic      [WIDTH-1:0]      top_from_compare_a,
    output logic                       ctc_clear_request,
    // interrupts
    input  wire logic [CHANNELS-1:0]   irq_ack,
    output logic      [CHANNELS-1:0]   irq_request,
    // port pins
    input  wire logic [CHANNELS-1:0]   port_data,
    input  wire logic [CHANNELS-1:0]   output_pin_direction_bit,
    output logic      [CHANNELS-1:0]   pin_out,
    output logic      [CHANNELS-1:0]   pin_oe,
    output logic      [CHANNELS-1:0]   compare_output_bit
);

    initial
    begin
        if (WIDTH != 2 * BYTE_WIDTH)
            $error("timer16_output_compare: WIDTH must be two bus bytes");
    end

    // =========================================================
    // mode decode
    mode_class_t mode_now;
    logic        is_pwm;
    logic        load_point;

    assign mode_now = mode_class(waveform_mode_select);
    assign is_pwm   = (mode_now != CLASS_NON_PWM);

    // loads ride on a tick, so a stopped counter never reloads
    // phase and frequency correct loads at bottom, the rest at top
    assign load_point = (mode_now == CLASS_PHASE_FREQ) ? counter_at_bottom : counter_at_top;

    // =========================================================
    // match blocking after a counter write
    logic block_pending;
    logic match_blocked;

    // block until a tick has passed
    // a write in a tick cycle also kills the match of the old count
    assign match_blocked = block_pending || counter_write;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            block_pending <= 1'b0;
        else if (counter_write)
            block_pending <= 1'b1;
        else if (timer_tick)
            block_pending <= 1'b0;
    end

    // =========================================================
    // register bus decode
    logic [BYTE_WIDTH-1:0] high_latch;
    logic [7:0]            control;
    logic                  control_write;
    logic                  flags_write;
    logic                  high_write;

    assign control_write = bus_wr && (bus_addr == ADDR_CONTROL);
    assign flags_write   = bus_wr && (bus_addr == ADDR_FLAGS);
    assign high_write    = bus_wr && ((bus_addr == ADDR_CMP_HIGH[0]) || (bus_addr == ADDR_CMP_HIGH[1]));

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            high_latch <= 8'h00;
        else if (high_write)
            high_latch <= bus_wdata;
    end

    // force bits are stored here but never read back or reused
    // action bits take effect at once, no shadow copy
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            control <= CONTROL_RESET;
        else if (control_write)
            control <= bus_wdata;
    end

    // =========================================================
    // channels
    logic [WIDTH-1:0]    compare_value [CHANNELS];
    logic [WIDTH-1:0]    active_value [CHANNELS];
    logic [CHANNELS-1:0] match;
    logic [CHANNELS-1:0] match_event;
    logic [CHANNELS-1:0] compare_match_flag;
    logic [CHANNELS-1:0] output_bit;

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++)
        begin : g_channel
            logic [1:0] action;
            logic       irq_enable;
            logic       low_write;
            logic       flag_clear;
            logic       forced;
            logic       fire;
            logic       next_bit;

            assign action     = control[CTRL_ACTION_LSB + 2 * ch +: 2];
            assign irq_enable = control[CTRL_IRQ_EN_LSB + ch];
            assign low_write  = bus_wr && (bus_addr == ADDR_CMP_LOW[ch]);

            assign flag_clear = flags_write && bus_wdata[FLAG_LSB + ch];

            // a force written together with a new action uses the action already
            // in place; the new setting governs from the next event on
            // force only outside PWM modes
            assign forced = control_write && bus_wdata[CTRL_FORCE_LSB + ch] && !is_pwm;
            assign fire   = match_event[ch] || forced;

            compare_channel #(
                .WIDTH (WIDTH)
            ) u_channel (
                .clk                (clk),
                .rst                (rst),
                .counter_value      (counter_value),
                .timer_tick         (timer_tick),
                .match_blocked      (match_blocked),
                .buffered           (is_pwm),
                .load_point         (load_point),
                .write_strobe       (low_write),
                .write_value        ({high_latch, bus_wdata}),
                .flag_clear         (flag_clear),
                .irq_ack            (irq_ack[ch]),
                .compare_value      (compare_value[ch]),
                .active_value       (active_value[ch]),
                .match              (match[ch]),
                .match_event        (match_event[ch]),
                .compare_match_flag (compare_match_flag[ch])
            );

            // the request drops as soon as service or software clears the flag
            // flag gated by enable
            assign irq_request[ch] = compare_match_flag[ch] && irq_enable;

            always_comb
            begin
                next_bit = output_bit[ch];
                case (mode_now)
                    CLASS_NON_PWM:
                    begin
                        if (fire)
                        begin
                            case (action)
                                ACTION_TOGGLE: next_bit = !output_bit[ch];
                                ACTION_CLEAR:  next_bit = 1'b0;
                                ACTION_SET:    next_bit = 1'b1;
                                default:       next_bit = output_bit[ch];
                            endcase
                        end
                    end
                    CLASS_FAST:
                    begin
                        // match has priority over top when both coincide
                        if (action == ACTION_CLEAR)
                        begin
                            if (match_event[ch])
                                next_bit = 1'b1;
                            else if (timer_tick && counter_at_top)
                                next_bit = 1'b0;
                        end
                        else if (action == ACTION_SET)
                        begin
                            if (match_event[ch])
                                next_bit = 1'b0;
                            else if (timer_tick && counter_at_top)
                                next_bit = 1'b1;
                        end
                    end
                    default:
                    begin
                        // dual slope: direction picks the level
                        if (match_event[ch] && action == ACTION_CLEAR)
                            next_bit = counter_counting_down;
                        else if (match_event[ch] && action == ACTION_SET)
                            next_bit = !counter_counting_down;
                    end
                endcase
            end

            // reset only, mode changes leave it alone
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                    output_bit[ch] <= OUTPUT_BIT_RESET;
                else
                    output_bit[ch] <= next_bit;
            end

            // the bit stays internal until the port direction selects output,
            // so software can preset it first
            // override port value, direction from the port
            assign pin_out[ch] = (action != ACTION_NONE) ? output_bit[ch] : port_data[ch];
            assign pin_oe[ch]  = output_pin_direction_bit[ch];
        end
    endgenerate

    assign compare_output_bit = output_bit;

    // =========================================================
    // counter top and clear requests
    logic capture_equal;

    // active value of channel A offered as top
    assign top_from_compare_a = active_value[0];

    // capture ignores action bits
    // the capture compare only feeds the mode 12 clear; the action field never
    // reaches it, so changing actions cannot disturb capture timing
    assign capture_equal      = (counter_value == capture_register);

    // clear-on-compare request, blocked like any match
    assign ctc_clear_request = timer_tick && !match_blocked
        && (((waveform_mode_select == MODE_CTC_COMPARE) && match[0])
        || ((waveform_mode_select == MODE_CTC_CAPTURE) && capture_equal));

    // =========================================================
    // read path
    logic [BYTE_WIDTH-1:0] read_value;
    logic [7:0]            control_view;
    logic [7:0]            flags_view;

    // force bits read back as zero
    assign control_view = {control[7:6], 2'b00, control[3:0]};
    assign flags_view   = {6'b000000, compare_match_flag};

    // reads have no side effects: only writes touch the shared latch
    // high byte comes straight from the register, not the latch
    assign read_value =
        (bus_addr == ADDR_CMP_LOW[0])  ? compare_value[0][7:0]  :
        (bus_addr == ADDR_CMP_HIGH[0]) ? compare_value[0][15:8] :
        (bus_addr == ADDR_CMP_LOW[1])  ? compare_value[1][7:0]  :
        (bus_addr == ADDR_CMP_HIGH[1]) ? compare_value[1][15:8] :
        (bus_addr == ADDR_CONTROL)     ? control_view           :
        (bus_addr == ADDR_FLAGS)       ? flags_view             :
                                         8'h00;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            bus_rdata <= 8'h00;
        else if (bus_rd)
            bus_rdata <= read_value;
    end

endmodule

//--- tb/timer16_oc_props.sv
`timescale 1ns/1ps

module timer16_oc_checker
    import timer16_oc_pkg::*;
#(
    parameter int WIDTH = COUNT_WIDTH
)
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // register bus
    input  wire logic [ADDR_WIDTH-1:0] bus_addr,
    input  wire logic                  bus_wr,
    input  wire logic [BYTE_WIDTH-1:0] bus_wdata,
    // counter unit
    input  wire logic [WIDTH-1:0]      counter_value,
    input  wire logic                  timer_tick,
    input  wire logic                  counter_write,
    input  wire logic [MODE_WIDTH-1:0] waveform_mode_select,
    input  wire logic [WIDTH-1:0]      top_from_compare_a,
    input  wire logic                  ctc_clear_request,
    // interrupts and pins
    input  wire logic [CHANNELS-1:0]   irq_ack,
    input  wire logic [CHANNELS-1:0]   irq_request,
    input  wire logic [CHANNELS-1:0]   port_data,
    input  wire logic [CHANNELS-1:0]   output_pin_direction_bit,
    input  wire logic [CHANNELS-1:0]   pin_out,
    input  wire logic [CHANNELS-1:0]   pin_oe,
    input  wire logic [CHANNELS-1:0]   compare_output_bit
);
    // =========================================================
    // shadow of the control register and of the match block
    logic [7:0] ctrl;
    logic       blk;
    wire        ctrl_wr = bus_wr && (bus_addr == ADDR_CONTROL);
    wire        hit_a   = timer_tick && (counter_value == top_from_compare_a) && !counter_write && !blk;
    wire        pwm     = !(waveform_mode_select inside {4'h0, 4'h4, 4'hc, 4'hd});
    wire [1:0]  mux_exp = {(ctrl[3:2] != 2'h0) ? compare_output_bit[1] : port_data[1],
                           (ctrl[1:0] != 2'h0) ? compare_output_bit[0] : port_data[0]};

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl <= 8'h00;
            blk  <= 1'b0;
        end
        else
        begin
            if (ctrl_wr)
                ctrl <= bus_wdata;
            // block lasts until the next tick edge has passed
            blk <= counter_write || (blk && !timer_tick);
        end
    end

    // =========================================================
    // properties
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_match_a;
        hit_a && ctrl[CTRL_IRQ_EN_LSB];
    endsequence

    a_pin_oe_direction: assert property (pin_oe == output_pin_direction_bit)
        else $error("pin enable differs from direction");
    a_pin_source_mux: assert property (pin_out == mux_exp)
        else $error("pin value from wrong source");
    a_reset_bit_low: assert property ($fell(rst) |-> compare_output_bit == 2'h0)
        else $error("output bit not cleared by reset");
    a_match_sets_flag: assert property (s_match_a |=> irq_request[0])
        else $error("match did not raise request");
    a_ack_clears_flag: assert property (irq_ack[0] && !timer_tick |=> !irq_request[0])
        else $error("service did not clear flag");
    a_write_blocks_clear: assert property (counter_write |-> !ctc_clear_request)
        else $error("clear request during counter write");
    a_ctc_clear_match: assert property (waveform_mode_select == MODE_CTC_COMPARE && hit_a |-> ctc_clear_request)
        else $error("no clear on compare match");
    a_none_keeps_bit: assert property (ctrl[1:0] == ACTION_NONE |=> $stable(compare_output_bit[0]))
        else $error("bit changed with no action");
    a_mode_keeps_bit: assert property ($changed(waveform_mode_select) && !timer_tick && !bus_wr |=>
                                       $stable(compare_output_bit))
        else $error("bit changed on mode change");
    a_force_no_flag: assert property (ctrl_wr && bus_wdata[CTRL_FORCE_LSB] && bus_wdata[CTRL_IRQ_EN_LSB] &&
                                      ctrl[CTRL_IRQ_EN_LSB] && !irq_request[0] && !timer_tick |=> !irq_request[0])
        else $error("force raised the flag");
    a_buffer_holds_top: assert property (pwm && !timer_tick |=> $stable(top_from_compare_a))
        else $error("active compare changed off a load point");
endmodule

bind timer16_output_compare timer16_oc_checker #(.WIDTH(WIDTH)) timer16_oc_checker_inst (
    .clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_wdata(bus_wdata),
    .counter_value(counter_value), .timer_tick(timer_tick), .counter_write(counter_write),
    .waveform_mode_select(waveform_mode_select), .top_from_compare_a(top_from_compare_a),
    .ctc_clear_request(ctc_clear_request), .irq_ack(irq_ack), .irq_request(irq_request),
    .port_data(port_data), .output_pin_direction_bit(output_pin_direction_bit), .pin_out(pin_out),
    .pin_oe(pin_oe), .compare_output_bit(compare_output_bit)
);

//--- tb/pin_model.sv
`timescale 1ns/1ps

module pin_model
(
    // drive from the block
    input  wire logic drive_value,
    input  wire logic drive_enable,
    // level seen by the external circuit
    output logic      pin_level
);
    logic last;

    // floating pin: no pull, so show the opposite of the last driven level
    initial last = 1'b0;
    always @(drive_value or drive_enable)
    begin
        if (drive_enable)
            last = drive_value;
    end
    assign pin_level = drive_enable ? drive_value : !last;
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps

module tb;
    import timer16_oc_pkg::*;
    typedef struct {logic [1:0] action; logic exp_bit;} row_t;

    logic        clk = 1'b0, rst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0, timer_tick = 1'b0;
    logic        counter_at_top = 1'b0, counter_write = 1'b0, down = 1'b0, bottom = 1'b0;
    logic [2:0]  bus_addr = 3'h0;
    logic [7:0]  bus_wdata = 8'h00, bus_rdata, d;
    logic [15:0] counter_value = 16'h0000, top_from_compare_a;
    logic [3:0]  waveform_mode_select = 4'h0;
    logic [1:0]  irq_ack = 2'h0, irq_request, port_data = 2'h0, dir = 2'h0, pin_out, pin_oe, obit;
    logic        ctc_clear_request, pin_level, clr;
    int          errors = 0, checks = 0;
    row_t        rows [5] = '{'{2'h3, 1'b1}, '{2'h1, 1'b0}, '{2'h1, 1'b1}, '{2'h0, 1'b1}, '{2'h2, 1'b0}};

    timer16_output_compare timer16_output_compare_inst (
        .clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .counter_value(counter_value), .timer_tick(timer_tick),
        .counter_at_top(counter_at_top), .counter_at_bottom(bottom), .counter_counting_down(down),
        .counter_write(counter_write), .capture_register(16'h0000), .waveform_mode_select(waveform_mode_select),
        .top_from_compare_a(top_from_compare_a), .ctc_clear_request(ctc_clear_request), .irq_ack(irq_ack),
        .irq_request(irq_request), .port_data(port_data), .output_pin_direction_bit(dir), .pin_out(pin_out),
        .pin_oe(pin_oe), .compare_output_bit(obit)
    );
    pin_model pin_model_inst (.drive_value(pin_out[0]), .drive_enable(pin_oe[0]), .pin_level(pin_level));

    initial
    begin
        forever #5 clk = !clk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        bus_wr    <= 1'b1;
        bus_addr  <= a;
        bus_wdata <= v;
        @(posedge clk);
        bus_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk);
        bus_rd   <= 1'b1;
        bus_addr <= a;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1;
        v = bus_rdata;
    endtask

    // one timer tick; the flag must still be low inside the match cycle
    task automatic tick(input logic [15:0] c, input logic top);
        @(posedge clk);
        timer_tick     <= 1'b1;
        counter_value  <= c;
        counter_at_top <= top;
        #1;
        chk(irq_request[0], 1'b0);
        clr = ctc_clear_request;
        @(posedge clk);
        timer_tick     <= 1'b0;
        counter_at_top <= 1'b0;
        #1;
    endtask

    task automatic pulse_ack();
        @(posedge clk);
        irq_ack <= 2'h1;
        @(posedge clk);
        irq_ack <= 2'h0;
        #1;
    endtask

    initial
    begin
        #200000;
        errors++;
        results();
    end

    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 7; a++)
        begin
            rd(a[2:0], d);
            chk(d, (a == 4) ? CONTROL_RESET : 8'h00);
        end
        chk(obit, 2'h0);
        wr(ADDR_CMP_HIGH[0], 8'h00);
        wr(ADDR_CMP_LOW[0], 8'h05);
        chk(top_from_compare_a, 16'h0005);
        // preset the bit by force before the pin becomes an output
        wr(ADDR_CONTROL, 8'h43);
        wr(ADDR_CONTROL, 8'h53);
        chk(obit[0], 1'b1);
        chk(irq_request[0], 1'b0);
        @(posedge clk);
        dir <= 2'h1;
        port_data <= 2'h2;
        // =========================================================
        // table of non-pwm actions on a real match
        foreach (rows[i])
        begin
            wr(ADDR_CONTROL, {6'h10, rows[i].action});
            tick(16'h0005, 1'b0);
            chk(obit[0], rows[i].exp_bit);
            chk(pin_level, (rows[i].action != 2'h0) ? rows[i].exp_bit : 1'b0);
            rd(ADDR_FLAGS, d);
            chk(d, 8'h01);
            wr(ADDR_FLAGS, 8'h00);
            chk(irq_request[0], 1'b1);
            wr(ADDR_FLAGS, 8'h01);
            chk(irq_request[0], 1'b0);
        end
        // =========================================================
        // shared high byte latch
        wr(ADDR_CMP_HIGH[1], 8'hab);
        wr(ADDR_CMP_LOW[1], 8'hcd);
        rd(ADDR_CMP_HIGH[1], d);
        chk(d, 8'hab);
        rd(ADDR_CMP_LOW[1], d);
        chk(d, 8'hcd);
        wr(ADDR_CMP_LOW[0], 8'h07);
        chk(top_from_compare_a, 16'hab07);
        wr(ADDR_CMP_HIGH[0], 8'h00);
        wr(ADDR_CMP_LOW[0], 8'h05);
        // =========================================================
        // counter write blocks the next tick, then service clears
        @(posedge clk);
        counter_write <= 1'b1;
        @(posedge clk);
        counter_write <= 1'b0;
        tick(16'h0005, 1'b0);
        chk(irq_request[0], 1'b0);
        tick(16'h0005, 1'b0);
        chk(irq_request[0], 1'b1);
        pulse_ack();
        chk(irq_request[0], 1'b0);
        // =========================================================
        // fast pwm: buffering, ignored force, set on match, clear at top
        @(posedge clk);
        waveform_mode_select <= 4'he;
        wr(ADDR_CONTROL, 8'h43);
        wr(ADDR_CONTROL, 8'h52);
        chk(obit[0], 1'b0);
        rd(ADDR_CONTROL, d);
        chk(d & 8'h30, 8'h00);
        wr(ADDR_CMP_HIGH[0], 8'h00);
        wr(ADDR_CMP_LOW[0], 8'h09);
        chk(top_from_compare_a, 16'h0005);
        rd(ADDR_CMP_LOW[0], d);
        chk(d, 8'h09);
        tick(16'h00ff, 1'b1);
        chk(top_from_compare_a, 16'h0009);
        tick(16'h0009, 1'b0);
        chk(obit[0], 1'b1);
        @(posedge clk);
        waveform_mode_select <= 4'h0;
        @(posedge clk);
        #1;
        chk(obit[0], 1'b1);
        wr(ADDR_FLAGS, 8'h01);
        @(posedge clk);
        waveform_mode_select <= 4'he;
        tick(16'h00ff, 1'b1);
        chk(obit[0], 1'b0);
        // =========================================================
        // clear on compare with channel a, then with the capture value
        wr(ADDR_CONTROL, 8'h00);
        @(posedge clk);
        waveform_mode_select <= MODE_CTC_COMPARE;
        tick(16'h0009, 1'b0);
        chk(clr, 1'b1);
        @(posedge clk);
        waveform_mode_select <= MODE_CTC_CAPTURE;
        tick(16'h0009, 1'b0);
        chk(clr, 1'b0);
        tick(16'h0000, 1'b0);
        chk(clr, 1'b1);
        // =========================================================
        // dual slope: level follows direction, buffer loads at bottom
        wr(ADDR_CONTROL, 8'h02);
        @(posedge clk);
        waveform_mode_select <= 4'h8;
        down   <= 1'b1;
        bottom <= 1'b1;
        wr(ADDR_CMP_LOW[0], 8'h0b);
        tick(16'h0009, 1'b0);
        chk(obit[0], 1'b1);
        chk(top_from_compare_a, 16'h000b);
        results();
    end
endmodule
